// >>> logic/mspc_consts.svh
// mspc_consts.svh: offsets, field positions, reset values and counts
// of the mode shared pin control block.
// assumes: included by bare name from logic/ and verification/ sources.
`ifndef MSPC_CONSTS_SVH
`define MSPC_CONSTS_SVH

`define MSPC_ADDR_W 12
`define MSPC_OFF_CTRL 12'h000
`define MSPC_OFF_STATUS 12'h004
`define MSPC_OFF_MASK 12'h008
`define MSPC_OFF_PINS 12'h00c

`define MSPC_CTRL_GIE_BIT 0
`define MSPC_CTRL_AUTO_ALL_ONES_ON_SIGNAL_LOSS_BIT 1
`define MSPC_CTRL_SYNC_BIT 2
`define MSPC_CTRL_RESET 3'h0
`define MSPC_MASK_RESET 8'hff

`define MSPC_CHANNELS 8
`define MSPC_EQ_BITS 5
`define MSPC_SETTLE_CYCLES 2'h2
`define MSPC_SYNC_W 26
// strap pin is pulled high, so it settles to hardware mode
`define MSPC_SYNC_RESET 26'h200_0000

`endif

// >>> logic/mspc_event_reg.sv
// mspc_event_reg.sv: sticky event status, set wins over clear.
// assumes: set and clear vectors come from the clk_sys domain.
`timescale 1ns/100ps
`default_nettype none
module mspc_event_reg
  import mspc_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  mspc_evt_if.owner evt
);
  logic [W-1:0] status_q;

  // an event landing in the clearing cycle is kept
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~evt.clr_vec) | evt.set_vec;
    end
  end

  assign evt.status = status_q;
endmodule
`default_nettype wire

// >>> logic/mspc_evt_if.sv
// mspc_evt_if.sv: event / clear / sticky status bundle between the top
// and its sticky status register.
// assumes: one owner (the status register) and one user (the top).
`timescale 1ns/100ps
`default_nettype none
interface mspc_evt_if #(parameter int W = 8);
  logic [W-1:0] set_vec;
  logic [W-1:0] clr_vec;
  logic [W-1:0] status;
  modport owner (input set_vec, input clr_vec, output status);
  modport user (output set_vec, output clr_vec, input status);
endinterface
`default_nettype wire

// >>> logic/mspc_pkg.sv
// mspc_pkg.sv: types shared by the mode shared pin control modules.
// assumes: compiled before every other logic/ file.
package mspc_pkg;

  typedef enum logic [1:0] {
    MSPC_LB_NONE = 2'h0,
    MSPC_LB_ANALOG = 2'h1,
    MSPC_LB_REMOTE = 2'h2,
    MSPC_LB_DIGITAL = 2'h3
  } mspc_loop_type;

  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_HARDWARE,
    ST_HOST
  } mspc_mode_type;

  typedef struct packed {
    logic enable;
    logic rx_path;
    logic narrow_bw;
  } mspc_jitter_type;

endpackage

// >>> logic/mspc_sync.sv
// mspc_sync.sv: two flip-flop synchroniser for asynchronous pins.
// assumes: one clock clk_sys, synchronous active high reset.
`timescale 1ns/100ps
`default_nettype none
module mspc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // meta_q feeds sync_q only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// >>> logic/mspc_top.sv
// mspc_top.sv: mode shared pin control of an eight channel line unit.
// assumes: APB slave on clk_sys; pins are asynchronous and synchronised;
// line and register core signals are on clk_sys.
// Overview of operation
// - Host mode, parallel port: the ready pin tells the cpu a cycle is done.
// - Host mode, serial port: the ready pin carries serial read-back data.
// - Strap mode: five shared pins set the equalizer control bits.
// - Host mode: the data pins form the 8-bit two-way cpu data bus.
// - Strap mode: data pins give loopback selects of channels four to seven.
// - Strap mode: address pins give loopback selects of channels zero to three.
// - Loopback code 00 none, 01 analog local, 10 remote, 11 digital.
// - Host mode with synchronous port: the port clock pin clocks the port.
// - Strap mode: with the all-ones pin high a lost channel sends all ones.
// - Host mode: a global control bit replaces the all-ones pin.
// - Host mode: any unmasked alarm change pulls the interrupt pin low.
// - Reading the status releases the interrupt pin high again.
// - Interrupts are made only while the global enable bit is set.
// - Jitter select 00 off, 01 tx 10 Hz, 10 rx 10 Hz, 11 rx 1.5 Hz wide fifo.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "mspc_consts.svh"
module mspc_top
  import mspc_pkg::*;
#(
  parameter int CHANNELS = `MSPC_CHANNELS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`MSPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic strap_or_cpu_select,
  input wire logic serial_parallel_port_select,
  input wire logic [3:0] eq_ctrl_low_pin,
  input wire logic equalizer_ctrl_bit_four_i,
  output logic equalizer_ctrl_bit_four_o,
  output logic equalizer_ctrl_bit_four_oe,
  input wire logic [7:0] data_pin_i,
  output logic [7:0] data_pin_o,
  output logic [7:0] data_pin_oe,
  input wire logic [7:0] addr_pin,
  input wire logic port_clk_or_all_ones,
  input wire logic [1:0] jitter_path_select,
  output logic int_n_o,
  output logic int_n_oe,
  input wire logic [CHANNELS-1:0] signal_loss,
  input wire logic [CHANNELS-1:0] alarm_state,
  input wire logic cpu_done,
  input wire logic cpu_serial_bit,
  input wire logic cpu_rd_drive,
  input wire logic [7:0] cpu_rd_data,
  input wire logic cpu_status_read,
  output logic host_mode,
  output logic serial_mode,
  output logic cpu_port_tick,
  output logic [7:0] cpu_addr,
  output logic [7:0] cpu_wr_data,
  output logic [`MSPC_EQ_BITS-1:0] equalizer_ctrl_bits,
  output logic [CHANNELS-1:0] lb_analog,
  output logic [CHANNELS-1:0] lb_remote,
  output logic [CHANNELS-1:0] lb_digital,
  output mspc_jitter_type jitter_cfg,
  output logic [CHANNELS-1:0] tx_all_ones
);

  function automatic logic reg_hit(input logic [`MSPC_ADDR_W-1:0] a,
                                   input logic [`MSPC_ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction

  function automatic mspc_loop_type decode_loop(input logic [1:0] code);
    decode_loop = mspc_loop_type'(code);
  endfunction

  function automatic mspc_jitter_type decode_jitter(input logic [1:0] sel);
    mspc_jitter_type j;
    j.enable = (sel != 2'h0);
    j.rx_path = sel[1];
    j.narrow_bw = (sel == 2'h3);
    decode_jitter = j;
  endfunction

  // pin synchronisation, one bank for every asynchronous input
  logic [`MSPC_SYNC_W-1:0] pins_s;
  logic strap_s;
  logic ser_s;
  logic [`MSPC_EQ_BITS-1:0] eq_s;
  logic [7:0] data_s;
  logic [7:0] addr_s;
  logic pclk_s;
  logic [1:0] ja_s;

  mspc_sync #(
    .W(`MSPC_SYNC_W),
    .RESET_VAL(`MSPC_SYNC_RESET)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({strap_or_cpu_select, serial_parallel_port_select,
               equalizer_ctrl_bit_four_i, eq_ctrl_low_pin, data_pin_i,
               addr_pin, port_clk_or_all_ones, jitter_path_select}),
    .sync_out(pins_s)
  );

  assign {strap_s, ser_s, eq_s, data_s, addr_s, pclk_s, ja_s} = pins_s;

  // mode state
  mspc_mode_type state_q;
  logic [1:0] settle_q;
  logic is_host;
  logic is_hw;

  assign is_host = (state_q == ST_HOST);
  assign is_hw = (state_q == ST_HARDWARE);

  // the strap is followed live; settling lets the synchroniser fill first
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= ST_SETTLE;
      settle_q <= 2'h0;
    end else begin
      case (state_q)
        ST_SETTLE: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == `MSPC_SETTLE_CYCLES) begin
            state_q <= strap_s ? ST_HARDWARE : ST_HOST;
          end
        end
        ST_HARDWARE: begin
          if (!strap_s) begin
            state_q <= ST_HOST;
          end
        end
        ST_HOST: begin
          if (strap_s) begin
            state_q <= ST_HARDWARE;
          end
        end
        default: begin
          state_q <= ST_SETTLE;
        end
      endcase
    end
  end

  // apb slave: access phase takes two cycles, pready from a flop
  logic [2:0] ctrl_q;
  logic [CHANNELS-1:0] mask_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic apb_access;
  logic apb_done;
  logic apb_wr;
  logic addr_ok;
  logic [31:0] rd_mux;

  mspc_evt_if #(.W(CHANNELS)) evt ();

  assign apb_access = psel & penable & ~pready_q;
  assign apb_done = psel & penable & pready_q;
  assign apb_wr = apb_done & pwrite & ~pslverr_q;
  assign addr_ok = reg_hit(paddr, `MSPC_OFF_CTRL) |
                   reg_hit(paddr, `MSPC_OFF_STATUS) |
                   reg_hit(paddr, `MSPC_OFF_MASK) |
                   reg_hit(paddr, `MSPC_OFF_PINS);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_hit(paddr, `MSPC_OFF_CTRL)) begin
      rd_mux[2:0] = ctrl_q;
    end else if (reg_hit(paddr, `MSPC_OFF_STATUS)) begin
      rd_mux[CHANNELS-1:0] = evt.status;
    end else if (reg_hit(paddr, `MSPC_OFF_MASK)) begin
      rd_mux[CHANNELS-1:0] = mask_q;
    end else if (reg_hit(paddr, `MSPC_OFF_PINS)) begin
      rd_mux[9:0] = {ja_s, eq_s, ser_s, is_hw, is_host};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apb_access;
      pslverr_q <= apb_access & ~addr_ok;
      if (apb_access && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // all writable fields sit in byte lane zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= `MSPC_CTRL_RESET;
      mask_q <= `MSPC_MASK_RESET;
    end else if (apb_wr && pstrb[0]) begin
      if (reg_hit(paddr, `MSPC_OFF_CTRL)) begin
        ctrl_q <= pwdata[2:0];
      end
      if (reg_hit(paddr, `MSPC_OFF_MASK)) begin
        mask_q <= pwdata[CHANNELS-1:0];
      end
    end
  end

  // alarm change events, cleared by write-one or by the cpu status read
  logic [CHANNELS-1:0] alarm_prev_q;
  logic [CHANNELS-1:0] alarm_chg;
  logic [CHANNELS-1:0] w1c_vec;
  logic irq_q;
  logic int_oe_q;
  logic pend;

  assign alarm_chg = alarm_state ^ alarm_prev_q;
  assign w1c_vec = (apb_wr && pstrb[0] && reg_hit(paddr, `MSPC_OFF_STATUS))
                   ? pwdata[CHANNELS-1:0] : '0;
  assign evt.set_vec = alarm_chg;
  assign evt.clr_vec = w1c_vec | {CHANNELS{cpu_status_read}};
  assign pend = ctrl_q[`MSPC_CTRL_GIE_BIT] & |(evt.status & mask_q);

  mspc_event_reg #(.W(CHANNELS)) u_evt (
    .clk_sys(clk_sys),
    .reset(reset),
    .evt(evt)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      alarm_prev_q <= '0;
      irq_q <= 1'b0;
      int_oe_q <= 1'b0;
    end else begin
      alarm_prev_q <= alarm_state;
      irq_q <= pend;
      int_oe_q <= is_host & pend;
    end
  end

  // host port: ready pin, data bus, address, port clock
  logic rdy_o_q;
  logic rdy_oe_q;
  logic [7:0] data_o_q;
  logic [7:0] data_oe_q;
  logic [7:0] cpu_addr_q;
  logic [7:0] cpu_wr_q;
  logic pclk_prev_q;
  logic tick_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdy_o_q <= 1'b0;
      rdy_oe_q <= 1'b0;
      data_o_q <= 8'h00;
      data_oe_q <= 8'h00;
      cpu_addr_q <= 8'h00;
      cpu_wr_q <= 8'h00;
    end else begin
      rdy_oe_q <= is_host;
      rdy_o_q <= ser_s ? cpu_serial_bit : cpu_done;
      data_oe_q <= {8{is_host & cpu_rd_drive}};
      data_o_q <= cpu_rd_data;
      cpu_wr_q <= is_host ? data_s : 8'h00;
      cpu_addr_q <= is_host ? addr_s : 8'h00;
    end
  end

  // rising port clock edges become one cycle ticks; clk_sys must be far faster
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pclk_prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      pclk_prev_q <= pclk_s;
      tick_q <= is_host & ctrl_q[`MSPC_CTRL_SYNC_BIT] &
                pclk_s & ~pclk_prev_q;
    end
  end

  // strap mode: equalizer, loopback, jitter attenuator
  logic [`MSPC_EQ_BITS-1:0] eq_q;
  logic [CHANNELS-1:0] lb_an_q;
  logic [CHANNELS-1:0] lb_rm_q;
  logic [CHANNELS-1:0] lb_dg_q;
  logic [2*CHANNELS-1:0] lb_code;
  mspc_jitter_type ja_q;
  logic [CHANNELS-1:0] taos_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      eq_q <= '0;
      ja_q <= '0;
    end else begin
      eq_q <= is_hw ? eq_s : '0;
      ja_q <= is_hw ? decode_jitter(ja_s) : '0;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_loop
      // address pins pair per channel; data pins run in reverse order
      assign lb_code[2*ch+1:2*ch] = addr_s[2*ch+1:2*ch];
      assign lb_code[2*(ch+4)+1:2*(ch+4)] = data_s[7-2*ch:6-2*ch];
    end
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          lb_an_q[ch] <= 1'b0;
          lb_rm_q[ch] <= 1'b0;
          lb_dg_q[ch] <= 1'b0;
        end else begin
          lb_an_q[ch] <= is_hw &&
            decode_loop(lb_code[2*ch+1:2*ch]) == MSPC_LB_ANALOG;
          lb_rm_q[ch] <= is_hw &&
            decode_loop(lb_code[2*ch+1:2*ch]) == MSPC_LB_REMOTE;
          lb_dg_q[ch] <= is_hw &&
            decode_loop(lb_code[2*ch+1:2*ch]) == MSPC_LB_DIGITAL;
        end
      end
    end
  endgenerate

  // all ones on signal loss: pin in strap mode, control bit in host mode
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      taos_q <= '0;
    end else if (is_host) begin
      taos_q <= signal_loss & {CHANNELS{ctrl_q[`MSPC_CTRL_AUTO_ALL_ONES_ON_SIGNAL_LOSS_BIT]}};
    end else if (is_hw) begin
      taos_q <= signal_loss & {CHANNELS{pclk_s}};
    end else begin
      taos_q <= '0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign int_n_o = 1'b0;
  assign int_n_oe = int_oe_q;
  assign equalizer_ctrl_bit_four_o = rdy_o_q;
  assign equalizer_ctrl_bit_four_oe = rdy_oe_q;
  assign data_pin_o = data_o_q;
  assign data_pin_oe = data_oe_q;
  assign host_mode = rdy_oe_q;
  assign serial_mode = ser_s;
  assign cpu_port_tick = tick_q;
  assign cpu_addr = cpu_addr_q;
  assign cpu_wr_data = cpu_wr_q;
  assign equalizer_ctrl_bits = eq_q;
  assign lb_analog = lb_an_q;
  assign lb_remote = lb_rm_q;
  assign lb_digital = lb_dg_q;
  assign jitter_cfg = ja_q;
  assign tx_all_ones = taos_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_MODE_FROM_STRAP: assert property (
    is_hw && !strap_s |=> is_host)
    else $error("low strap did not give host mode");
  AST_RDY_DONE: assert property (
    is_host && !ser_s |=> rdy_oe_q && rdy_o_q == $past(cpu_done))
    else $error("ready pin does not follow completion");
  AST_RDY_SERIAL: assert property (
    is_host && ser_s |=> rdy_o_q == $past(cpu_serial_bit))
    else $error("ready pin does not carry serial data");
  AST_EQ_BITS: assert property (
    is_hw ##1 is_hw |=> eq_q == $past(eq_s))
    else $error("equalizer bits not taken from pins");
  AST_DATA_DRIVE: assert property (
    is_host && cpu_rd_drive |=> data_oe_q == 8'hff
      && data_o_q == $past(cpu_rd_data))
    else $error("data bus not driven with read data");
  AST_LOOP_HIGH: assert property (
    is_hw && data_s[1:0] == 2'h3 |=> lb_dg_q[7] && !lb_an_q[7])
    else $error("channel seven loopback wrong");
  AST_LOOP_LOW: assert property (
    is_hw && addr_s[3:2] == 2'h1 |=> lb_an_q[1] && !lb_rm_q[1])
    else $error("channel one loopback wrong");
  AST_PORT_TICK: assert property (
    tick_q |-> $past(is_host && ctrl_q[`MSPC_CTRL_SYNC_BIT]))
    else $error("port tick outside synchronous host mode");
  AST_TAOS_PIN: assert property (
    is_hw && pclk_s && signal_loss[3] |=> taos_q[3])
    else $error("lost channel did not send all ones");
  AST_TAOS_BIT: assert property (
    is_host |=> taos_q == $past(signal_loss &
      {CHANNELS{ctrl_q[`MSPC_CTRL_AUTO_ALL_ONES_ON_SIGNAL_LOSS_BIT]}}))
    else $error("all ones not under control bit");
  AST_INT_ON_CHANGE: assert property (
    is_host && ctrl_q[0] && |(alarm_chg & mask_q) |=> ##1 int_oe_q)
    else $error("alarm change did not pull interrupt");
  AST_INT_RELEASE: assert property (
    cpu_status_read && alarm_chg == '0 |=> evt.status == '0 ##1 !int_oe_q)
    else $error("status read did not release interrupt");
  AST_INT_GIE: assert property (
    int_oe_q || irq_q |-> $past(ctrl_q[`MSPC_CTRL_GIE_BIT]))
    else $error("interrupt without global enable");
  AST_JITTER: assert property (
    is_hw && ja_s == 2'h1 |=> ja_q.enable && !ja_q.rx_path && !ja_q.narrow_bw)
    else $error("jitter select decode wrong");
  AST_HOST_NO_STRAP: assert property (
    is_host |=> lb_an_q == '0 && lb_dg_q == '0 && eq_q == '0)
    else $error("strap meaning used in host mode");

  COV_HOST_READ: cover property (is_host && cpu_rd_drive ##1 data_oe_q[0]);
  COV_INT_CYCLE: cover property (int_oe_q ##[1:20] !int_oe_q);
  COV_HW_TAOS: cover property (is_hw ##1 taos_q != '0);
  COV_APB_WRITE: cover property (apb_wr);

endmodule
`default_nettype wire

// >>> verification/mspc_host_model.sv
// mspc_host_model.sv: board straps and host cpu on the shared pins.
// assumes: inputs come from bench flops on clk_sys; pins resolve here.
`timescale 1ns/100ps
`default_nettype none
module mspc_host_model (
  input wire logic want_host,
  input wire logic [7:0] addr_val,
  input wire logic [7:0] data_val,
  input wire logic data_drive,
  input wire logic [4:0] eq_val,
  input wire logic [7:0] dev_data_o,
  input wire logic [7:0] dev_data_oe,
  input wire logic dev_eq4_o,
  input wire logic dev_eq4_oe,
  output logic strap_pin,
  output logic [7:0] addr_pin,
  output logic [7:0] data_pin,
  output logic [3:0] eq_low_pin,
  output logic eq4_pin
);
  // a released strap pin floats to its pull-up, which means strap mode
  assign strap_pin = want_host ? 1'b0 : 1'b1;
  assign addr_pin = addr_val;
  assign eq_low_pin = eq_val[3:0];
  // shared ready pin is pulled low in host mode while nobody drives it; in strap mode it carries eq_val[4]
  assign eq4_pin = dev_eq4_oe ? dev_eq4_o : (!want_host && eq_val[4]);
  // a clash on a data line shows unknown; released lines pull low
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dev_data_oe[i] && data_drive) data_pin[i] = 1'bx;
      else if (dev_data_oe[i]) data_pin[i] = dev_data_o[i];
      else if (data_drive) data_pin[i] = data_val[i];
      else data_pin[i] = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> verification/mspc_top_test.sv
// mspc_top_test.sv: self-checking bench of the shared pin control.
// assumes: logic/ files compiled first; one clock, 125 MHz.
`timescale 1ns/100ps
`default_nettype none
`include "mspc_consts.svh"
module mspc_top_test
  import mspc_pkg::*;
;
  logic clk_sys, reset, psel, penable, pwrite, want_host, ser, aux;
  logic data_drive, done, sbit, rdrv, sread;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] addr_val, data_val, loss, alarm, rdat;
  logic [4:0] eq_val;
  logic [1:0] jit;
  logic pready, pslverr, irq, eq4_o, eq4_oe, int_n_o, int_n_oe, host_m;
  logic ser_m, tick, strap_pin, eq4_pin;
  logic [7:0] data_o, data_oe, cpu_addr, cpu_wd, lba, lbr, lbd, taos;
  logic [7:0] addr_pin, data_pin;
  logic [3:0] eq_low;
  logic [4:0] eqb;
  mspc_jitter_type jcfg;
  int err_total = 0;
  int samples_checked = 0;

  mspc_top mspc_top_inst (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .strap_or_cpu_select(strap_pin),
    .serial_parallel_port_select(ser), .eq_ctrl_low_pin(eq_low),
    .equalizer_ctrl_bit_four_i(eq4_pin), .equalizer_ctrl_bit_four_o(eq4_o),
    .equalizer_ctrl_bit_four_oe(eq4_oe), .data_pin_i(data_pin),
    .data_pin_o(data_o), .data_pin_oe(data_oe), .addr_pin(addr_pin),
    .port_clk_or_all_ones(aux), .jitter_path_select(jit),
    .int_n_o(int_n_o), .int_n_oe(int_n_oe), .signal_loss(loss),
    .alarm_state(alarm), .cpu_done(done), .cpu_serial_bit(sbit),
    .cpu_rd_drive(rdrv), .cpu_rd_data(rdat), .cpu_status_read(sread),
    .host_mode(host_m), .serial_mode(ser_m), .cpu_port_tick(tick),
    .cpu_addr(cpu_addr), .cpu_wr_data(cpu_wd), .equalizer_ctrl_bits(eqb),
    .lb_analog(lba), .lb_remote(lbr), .lb_digital(lbd),
    .jitter_cfg(jcfg), .tx_all_ones(taos));

  mspc_host_model mspc_host_model_inst (.want_host(want_host),
    .addr_val(addr_val), .data_val(data_val), .data_drive(data_drive),
    .eq_val(eq_val), .dev_data_o(data_o), .dev_data_oe(data_oe),
    .dev_eq4_o(eq4_o), .dev_eq4_oe(eq4_oe), .strap_pin(strap_pin),
    .addr_pin(addr_pin), .data_pin(data_pin), .eq_low_pin(eq_low),
    .eq4_pin(eq4_pin));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // waits for pready without assuming a latency
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      err_total++;
      $display("CHECK FAILED pready expected 1 seen timeout");
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0000_0000, rd, er);
    chk(nm, exp, rd);
    chk("pslverr", {31'h0000_0000, exp_err}, {31'h0000_0000, er});
  endtask

  task automatic sc_regs();
    rdchk("ctrl", `MSPC_OFF_CTRL, 32'h0000_0000, 1'b0);
    rdchk("mask", `MSPC_OFF_MASK, 32'h0000_00ff, 1'b0);
    wr(12'h010, 32'h0000_00ff);
    rdchk("unmapped", 12'h010, 32'h0000_0000, 1'b1);
  endtask

  task automatic sc_strap();
    logic [2:0] jexp [4] = '{3'b000, 3'b100, 3'b110, 3'b111};
    // channel codes 0..3 land at different bit positions on each bus
    addr_val <= 8'he4;
    data_val <= 8'h1b;
    eq_val <= 5'h1a;
    aux <= 1'b1;
    loss <= 8'h5a;
    step(8);
    chk("host_mode", 32'h0, host_m);
    chk("lb_analog", 32'h22, lba);
    chk("lb_remote", 32'h44, lbr);
    chk("lb_digital", 32'h88, lbd);
    chk("eq_bits", 32'h1a, eqb);
    chk("eq4_oe", 32'h0, eq4_oe);
    chk("all_ones", 32'h5a, taos);
    aux <= 1'b0;
    step(6);
    chk("all_ones", 32'h0, taos);
    for (int j = 0; j < 4; j++) begin
      jit <= j[1:0];
      step(6);
      chk("jitter", {29'h0, jexp[j]}, jcfg);
    end
    rdchk("pins", `MSPC_OFF_PINS, 32'h0000_03d2, 1'b0);
  endtask

  task automatic sc_host();
    int cnt;
    want_host <= 1'b1;
    addr_val <= 8'h5c;
    data_val <= 8'h96;
    done <= 1'b1;
    step(10);
    chk("host_mode", 32'h1, host_m);
    chk("cpu_addr", 32'h5c, cpu_addr);
    chk("cpu_wr_data", 32'h96, cpu_wd);
    chk("strap lb", 32'h0, {lba, lbr, lbd});
    chk("strap eq", 32'h0, {eqb, jcfg});
    chk("ready oe", 32'h1, eq4_oe);
    chk("ready", 32'h1, eq4_pin);
    done <= 1'b0;
    step(5);
    chk("ready", 32'h0, eq4_pin);
    ser <= 1'b1;
    sbit <= 1'b1;
    step(6);
    chk("readback", 32'h1, eq4_pin);
    chk("serial_mode", 32'h1, ser_m);
    sbit <= 1'b0;
    step(5);
    chk("readback", 32'h0, eq4_pin);
    ser <= 1'b0;
    data_drive <= 1'b0;
    rdrv <= 1'b1;
    rdat <= 8'hc3;
    step(5);
    chk("data oe", 32'hff, data_oe);
    chk("data bus", 32'hc3, data_pin);
    rdrv <= 1'b0;
    step(5);
    chk("data oe", 32'h0, data_oe);
    loss <= 8'h81;
    aux <= 1'b1;
    step(6);
    chk("all_ones pin", 32'h0, taos);
    wr(`MSPC_OFF_CTRL, 32'h0000_0006);
    aux <= 1'b0;
    step(6);
    chk("all_ones bit", 32'h81, taos);
    cnt = 0;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_sys);
      if (tick === 1'b1) cnt++;
      aux <= ((i / 4) % 2) == 1;
    end
    chk("port ticks", 32'h3, 32'(cnt));
  endtask

  task automatic sc_irq();
    wr(`MSPC_OFF_CTRL, 32'h0000_0000);
    alarm <= 8'h01;
    step(4);
    chk("irq gie off", 32'h0, {irq, int_n_oe});
    rdchk("status", `MSPC_OFF_STATUS, 32'h1, 1'b0);
    wr(`MSPC_OFF_CTRL, 32'h0000_0001);
    step(3);
    chk("irq", 32'h3, {irq, int_n_oe});
    chk("int pin level", 32'h0, int_n_o);
    sread <= 1'b1;
    @(posedge clk_sys);
    sread <= 1'b0;
    step(4);
    chk("irq released", 32'h0, {irq, int_n_oe});
    alarm <= 8'h00;
    step(4);
    chk("irq", 32'h3, {irq, int_n_oe});
    wr(`MSPC_OFF_STATUS, 32'h0000_0001);
    step(3);
    chk("irq w1c", 32'h0, {irq, int_n_oe});
    wr(`MSPC_OFF_MASK, 32'h0000_00fe);
    alarm <= 8'h01;
    step(4);
    chk("irq masked", 32'h0, {irq, int_n_oe});
    wr(`MSPC_OFF_MASK, 32'h0000_00ff);
    step(3);
    chk("irq unmasked", 32'h3, {irq, int_n_oe});
  endtask

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    want_host = 1'b0;
    ser = 1'b0;
    aux = 1'b0;
    data_drive = 1'b1;
    done = 1'b0;
    sbit = 1'b0;
    rdrv = 1'b0;
    sread = 1'b0;
    addr_val = 8'h00;
    data_val = 8'h00;
    loss = 8'h00;
    alarm = 8'h00;
    rdat = 8'h00;
    eq_val = 5'h00;
    jit = 2'h0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    sc_regs();
    sc_strap();
    sc_host();
    sc_irq();
    tally_and_finish();
  end
endmodule
`default_nettype wire
